// ==== design/fsr1_pkg.sv ====
// package of constants and types for the flash status register one block
package fsr1_pkg;
	// command opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_VWREN = 8'h50;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_ERASE4 = 8'h20;
	localparam logic [7:0] OP_ERASE32 = 8'h52;
	localparam logic [7:0] OP_ERASE64 = 8'hd8;
	localparam logic [7:0] OP_CHIP_A = 8'h60;
	localparam logic [7:0] OP_CHIP_B = 8'hc7;

	// status register fields
	localparam int SR_SEL_LOW_BIT = 7;
	localparam int SR_GRAN_BIT = 6;
	localparam int SR_DIR_BIT = 5;
	localparam int SR_REGION_HI = 4;
	localparam int SR_REGION_LO = 2;
	localparam int SR_WEL_BIT = 1;
	localparam int SR_BUSY_BIT = 0;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [2:0] REGION_NONE = 3'h0;
	localparam logic [2:0] REGION_FULL = 3'h7;

	// array geometry
	localparam int ADDR_W = 24;
	localparam int MEM_LOG2 = 21;
	localparam logic [4:0] GRAN64_LOG2 = 5'h10;
	localparam logic [4:0] GRAN4_LOG2 = 5'h0c;

	// whole-byte lengths of complete commands, opcode included
	localparam logic [2:0] LEN_SIMPLE = 3'h1;
	localparam logic [2:0] LEN_WRSR = 3'h2;
	localparam logic [2:0] LEN_ERASE = 3'h4;
	localparam logic [2:0] LEN_PROG = 3'h5;

	// non-volatile status store time
	localparam int T_NVWR_NS = 5000;
	localparam int CLK_MHZ = 250;
	localparam int NVWR_CYC = (T_NVWR_NS * CLK_MHZ) / 1000;

	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_WREN = 4'h1,
		CMD_WRDI = 4'h2,
		CMD_VWREN = 4'h3,
		CMD_RDSR = 4'h4,
		CMD_WRSR = 4'h5,
		CMD_PROG = 4'h6,
		CMD_ERASE = 4'h7,
		CMD_CHIP = 4'h8
	} fsr1_cmd_t;

	typedef enum logic [1:0] {
		ST_OPCODE = 2'h0,
		ST_COLLECT = 2'h1,
		ST_SKIP = 2'h2
	} fsr1_state_t;

	typedef enum logic [2:0] {
		KIND_PROG = 3'h0,
		KIND_ERASE4 = 3'h1,
		KIND_ERASE32 = 3'h2,
		KIND_ERASE64 = 3'h3,
		KIND_CHIP = 3'h4
	} fsr1_kind_t;

	typedef enum logic [1:0] {
		PMODE_SOFT = 2'h0,
		PMODE_HARD = 2'h1,
		PMODE_SUPPLY = 2'h2,
		PMODE_OTP = 2'h3
	} fsr1_pmode_t;
endpackage

// ==== design/fsr1_link_if.sv ====
// interface joining the control core, the serial shifter and the store timer
`timescale 1ns/1ps
interface fsr1_link_if (
	input wire logic clk_sys,
	input wire logic nrst
);
	logic ce;
	logic byte_stb;
	logic [7:0] rx_byte;
	logic [2:0] byte_cnt;
	logic at_boundary;
	logic frame_end;
	logic [7:0] tx_byte;
	logic miso;
	logic op_start;
	logic op_busy;
	logic op_done;

	modport ctrl (input clk_sys, nrst, byte_stb, rx_byte, byte_cnt, at_boundary, frame_end,
		miso, op_busy, op_done, output ce, tx_byte, op_start);
	modport shift (input clk_sys, nrst, ce, tx_byte,
		output byte_stb, rx_byte, byte_cnt, at_boundary, frame_end, miso);
	modport timer (input clk_sys, nrst, ce, op_start, output op_busy, op_done);
endinterface

// ==== design/fsr1_spi_shift.sv ====
// serial shifter: samples the spi pins, frames bytes and shifts reply bytes out
`timescale 1ns/1ps
module fsr1_spi_shift
	import fsr1_pkg::*;
(
	// link to the core
	fsr1_link_if.shift lk,
	// spi pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi
);
	logic sck_ff;
	logic cs_ff;
	logic [2:0] bitpos_ff;
	logic [6:0] rx_sh_ff;
	logic [7:0] tx_sh_ff;
	logic byte_stb_ff;
	logic [7:0] rx_byte_ff;
	logic [2:0] byte_cnt_ff;
	logic frame_end_ff;
	logic miso_ff;

	wire sck_rise = !sck_ff && sck && !cs_n;
	wire sck_fall = sck_ff && !sck && !cs_n;
	wire cs_fall = cs_ff && !cs_n;
	wire cs_rise = !cs_ff && cs_n;

	always_ff @(posedge lk.clk_sys or negedge lk.nrst) begin
		if (!lk.nrst) begin
			sck_ff <= 1'b0;
			cs_ff <= 1'b1;
			bitpos_ff <= 3'h0;
			rx_sh_ff <= 7'h00;
			tx_sh_ff <= 8'h00;
			byte_stb_ff <= 1'b0;
			rx_byte_ff <= 8'h00;
			byte_cnt_ff <= 3'h0;
			frame_end_ff <= 1'b0;
			miso_ff <= 1'b0;
		end else if (lk.ce) begin
			sck_ff <= sck;
			cs_ff <= cs_n;
			byte_stb_ff <= 1'b0;
			frame_end_ff <= cs_rise;
			if (cs_fall) begin
				bitpos_ff <= 3'h0;
				byte_cnt_ff <= 3'h0;
				tx_sh_ff <= 8'h00;
			end else if (sck_rise) begin
				rx_sh_ff <= {rx_sh_ff[5:0], mosi};
				bitpos_ff <= bitpos_ff + 3'h1;
				if (bitpos_ff == 3'h7) begin
					byte_stb_ff <= 1'b1;
					rx_byte_ff <= {rx_sh_ff, mosi};
					// saturates: longer frames only need to be known as long enough
					if (byte_cnt_ff != 3'h7) begin
						byte_cnt_ff <= byte_cnt_ff + 3'h1;
					end
					tx_sh_ff <= lk.tx_byte;
				end
			end else if (sck_fall) begin
				miso_ff <= tx_sh_ff[7];
				tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
			end
		end
	end

	assign lk.byte_stb = byte_stb_ff;
	assign lk.rx_byte = rx_byte_ff;
	assign lk.byte_cnt = byte_cnt_ff;
	assign lk.at_boundary = (bitpos_ff == 3'h0);
	assign lk.frame_end = frame_end_ff;
	assign lk.miso = miso_ff;
endmodule

// ==== design/fsr1_nv_timer.sv ====
// timer for the slow store of the status value into non-volatile memory
`timescale 1ns/1ps
module fsr1_nv_timer
	import fsr1_pkg::*;
(
	// link to the core
	fsr1_link_if.timer lk
);
	localparam logic [15:0] LAST_CNT = 16'(NVWR_CYC - 1);

	logic [15:0] cnt_ff;
	logic busy_ff;
	logic done_ff;

	always_ff @(posedge lk.clk_sys or negedge lk.nrst) begin
		if (!lk.nrst) begin
			cnt_ff <= 16'h0000;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (lk.ce) begin
			done_ff <= 1'b0;
			if (lk.op_start && !busy_ff) begin
				busy_ff <= 1'b1;
				cnt_ff <= 16'h0000;
			end else if (busy_ff) begin
				if (cnt_ff == LAST_CNT) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 16'h0001;
				end
			end
		end
	end

	assign lk.op_busy = busy_ff;
	assign lk.op_done = done_ff;
endmodule

// ==== design/fsr1_core.sv ====
// status register one of a serial flash: protection fields, write enable latch, busy
`timescale 1ns/1ps
module fsr1_core
	import fsr1_pkg::*;
(
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	// spi pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// protection pins and neighbours
	input wire logic wp_n,
	input wire logic protect_select_high,
	// array engine
	input wire logic eng_busy,
	input wire logic eng_done,
	output logic eng_req,
	output logic [2:0] eng_kind,
	output logic [ADDR_W-1:0] eng_addr,
	// observed state
	output logic [7:0] status_value,
	output logic [7:0] nv_copy,
	output logic [1:0] protect_mode
);
	function automatic fsr1_cmd_t decode_cmd(input logic [7:0] op);
		case (op)
			OP_WREN: decode_cmd = CMD_WREN;
			OP_WRDI: decode_cmd = CMD_WRDI;
			OP_VWREN: decode_cmd = CMD_VWREN;
			OP_RDSR: decode_cmd = CMD_RDSR;
			OP_WRSR: decode_cmd = CMD_WRSR;
			OP_PROG: decode_cmd = CMD_PROG;
			OP_ERASE4, OP_ERASE32, OP_ERASE64: decode_cmd = CMD_ERASE;
			OP_CHIP_A, OP_CHIP_B: decode_cmd = CMD_CHIP;
			default: decode_cmd = CMD_NONE;
		endcase
	endfunction

	function automatic logic region_hit(input logic [ADDR_W-1:0] a, input logic [7:0] sr);
		logic [2:0] bp;
		logic [4:0] slog;
		logic [MEM_LOG2:0] span;
		logic [MEM_LOG2:0] off;
		logic [MEM_LOG2:0] top;
		bp = sr[SR_REGION_HI:SR_REGION_LO];
		slog = (sr[SR_GRAN_BIT] ? GRAN4_LOG2 : GRAN64_LOG2) + {2'h0, bp} - 5'h01;
		span = (MEM_LOG2 + 1)'(1) << slog;
		off = {1'b0, a[MEM_LOG2-1:0]};
		top = (MEM_LOG2 + 1)'(1) << MEM_LOG2;
		if (bp == REGION_NONE) begin
			region_hit = 1'b0;
		end else if (bp == REGION_FULL) begin
			region_hit = 1'b1;
		end else if (sr[SR_DIR_BIT]) begin
			region_hit = (off >= (top - span));
		end else begin
			region_hit = (off < span);
		end
	endfunction

	fsr1_link_if lk (
		.clk_sys(clk_sys),
		.nrst(nrst)
	);

	fsr1_spi_shift u_shift (
		.lk(lk),
		.cs_n(cs_n),
		.sck(sck),
		.mosi(mosi)
	);

	fsr1_nv_timer u_timer (
		.lk(lk)
	);

	fsr1_state_t state_ff;
	fsr1_cmd_t cmd_ff;
	logic [7:0] op_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [7:0] data_ff;
	logic [7:2] fields_ff;
	logic wel_ff;
	logic vol_en_ff;
	logic eng_pend_ff;
	logic [7:0] nv_copy_ff;
	logic eng_req_ff;
	logic [2:0] eng_kind_ff;
	logic [ADDR_W-1:0] eng_addr_ff;
	logic [7:0] status_ff;
	logic [1:0] pmode_ff;
	logic nv_start_ff;

	fsr1_state_t nxt_state;
	fsr1_cmd_t nxt_cmd;

	// live register value; bit 0 covers both the store timer and the array engine
	wire busy_now = lk.op_busy || eng_busy || eng_pend_ff || nv_start_ff;
	wire [7:0] sr_now = {fields_ff, wel_ff, busy_now};
	// refreshed every byte so a polling host sees busy fall
	assign lk.tx_byte = sr_now;
	assign lk.ce = ce;
	assign lk.op_start = nv_start_ff;

	// protection mode from both select bits; the pin only enters the status write lock
	wire sel_low = fields_ff[SR_SEL_LOW_BIT];
	wire [1:0] pmode_now = {protect_select_high, sel_low};
	wire sr_locked = protect_select_high || (sel_low && !wp_n);

	// frame-end classification
	wire fe = lk.frame_end;
	wire bnd = lk.at_boundary;
	wire [2:0] nb = lk.byte_cnt;
	wire in_collect = (state_ff == ST_COLLECT);
	wire is_wrsr = in_collect && (cmd_ff == CMD_WRSR);
	wire is_prog = in_collect && (cmd_ff == CMD_PROG);
	wire is_erase = in_collect && (cmd_ff == CMD_ERASE);
	wire is_chip = in_collect && (cmd_ff == CMD_CHIP);
	wire full_wrsr = is_wrsr && (nb >= LEN_WRSR);
	wire full_prog = is_prog && (nb >= LEN_PROG);
	wire full_erase = is_erase && (nb >= LEN_ERASE);
	wire full_chip = is_chip && (nb >= LEN_SIMPLE);
	wire exact_simple = bnd && (nb == LEN_SIMPLE);
	wire ok_wrsr = full_wrsr && bnd && (nb == LEN_WRSR);
	wire ok_prog = full_prog && bnd;
	wire ok_erase = full_erase && bnd && (nb == LEN_ERASE);
	wire ok_chip = full_chip && exact_simple;
	wire any_full = full_wrsr || full_prog || full_erase || full_chip;
	wire any_ok = ok_wrsr || ok_prog || ok_erase || ok_chip;
	// whole command shifted in but chip select rose off a byte edge, or late for any command but program
	wire cut_short = fe && any_full && !any_ok;

	wire wrsr_allowed = (wel_ff || vol_en_ff) && !sr_locked;
	wire do_wrsr = fe && ok_wrsr && wrsr_allowed;
	wire do_nv = do_wrsr && wel_ff;
	wire region_set = (fields_ff[SR_REGION_HI:SR_REGION_LO] != REGION_NONE);
	wire hit = region_hit(addr_ff, sr_now) || (ok_chip && region_set);
	wire arr_cmd = ok_prog || ok_erase || ok_chip;
	wire arr_try = fe && arr_cmd && wel_ff;
	wire do_arr = arr_try && !hit;
	wire refused = arr_try && hit;
	wire do_wren = fe && in_collect && (cmd_ff == CMD_WREN) && exact_simple;
	wire do_wrdi = fe && in_collect && (cmd_ff == CMD_WRDI) && exact_simple;
	wire do_vwren = fe && in_collect && (cmd_ff == CMD_VWREN) && exact_simple;
	wire op_finish = lk.op_done || (eng_pend_ff && eng_done);

	// one byte's worth of command sequencing
	always_comb begin
		nxt_state = state_ff;
		nxt_cmd = cmd_ff;
		if (fe) begin
			nxt_state = ST_OPCODE;
			nxt_cmd = CMD_NONE;
		end else if (lk.byte_stb) begin
			case (state_ff)
				ST_OPCODE: begin
					nxt_cmd = decode_cmd(lk.rx_byte);
					// only status reads are served while an operation runs
					if (busy_now && (decode_cmd(lk.rx_byte) != CMD_RDSR)) begin
						nxt_state = ST_SKIP;
					end else begin
						nxt_state = ST_COLLECT;
					end
				end
				ST_COLLECT: nxt_state = ST_COLLECT;
				ST_SKIP: nxt_state = ST_SKIP;
				default: nxt_state = ST_OPCODE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_OPCODE;
			cmd_ff <= CMD_NONE;
		end else if (ce) begin
			state_ff <= nxt_state;
			cmd_ff <= nxt_cmd;
		end
	end

	// opcode, address and data capture
	wire cap_op = lk.byte_stb && (state_ff == ST_OPCODE);
	wire cap_addr = lk.byte_stb && in_collect && (nb <= LEN_ERASE);
	wire cap_data = lk.byte_stb && is_wrsr && (nb == LEN_WRSR);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			op_ff <= 8'h00;
			addr_ff <= 24'h000000;
			data_ff <= 8'h00;
		end else if (ce) begin
			if (cap_op) begin
				op_ff <= lk.rx_byte;
			end
			if (cap_addr) begin
				addr_ff <= {addr_ff[ADDR_W-9:0], lk.rx_byte};
			end
			if (cap_data) begin
				data_ff <= lk.rx_byte;
			end
		end
	end

	// writable fields: only a granted status write changes them
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fields_ff <= SR_RESET[7:2];
			nv_copy_ff <= SR_RESET;
			nv_start_ff <= 1'b0;
		end else if (ce) begin
			nv_start_ff <= do_nv;
			if (do_wrsr) begin
				fields_ff <= data_ff[7:2];
			end
			// a volatile-enabled write reaches the stored copy only when the write enable latch is also set
			if (do_nv) begin
				nv_copy_ff <= {data_ff[7:2], 2'h0};
			end
		end
	end

	// write enable latch; a set in the same cycle as a clear wins
	wire wel_clr = op_finish || cut_short || refused || do_wrdi;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wel_ff <= 1'b0;
		end else if (ce) begin
			if (do_wren) begin
				wel_ff <= 1'b1;
			end else if (wel_clr) begin
				wel_ff <= 1'b0;
			end
		end
	end

	// volatile enable is spent by one status write
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			vol_en_ff <= 1'b0;
		end else if (ce) begin
			if (do_vwren) begin
				vol_en_ff <= 1'b1;
			end else if (do_wrsr || do_wren || do_wrdi) begin
				vol_en_ff <= 1'b0;
			end
		end
	end

	// array engine request; the latch stays set until the engine reports done
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			eng_req_ff <= 1'b0;
			eng_kind_ff <= KIND_PROG;
			eng_addr_ff <= 24'h000000;
			eng_pend_ff <= 1'b0;
		end else if (ce) begin
			eng_req_ff <= do_arr;
			if (do_arr) begin
				eng_pend_ff <= 1'b1;
				eng_addr_ff <= addr_ff;
				case (op_ff)
					OP_ERASE4: eng_kind_ff <= KIND_ERASE4;
					OP_ERASE32: eng_kind_ff <= KIND_ERASE32;
					OP_ERASE64: eng_kind_ff <= KIND_ERASE64;
					OP_PROG: eng_kind_ff <= KIND_PROG;
					default: eng_kind_ff <= KIND_CHIP;
				endcase
			end else if (eng_done) begin
				eng_pend_ff <= 1'b0;
			end
		end
	end

	// observation registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			status_ff <= SR_RESET;
			pmode_ff <= PMODE_SOFT;
		end else if (ce) begin
			status_ff <= sr_now;
			pmode_ff <= pmode_now;
		end
	end

	assign miso = lk.miso;
	assign eng_req = eng_req_ff;
	assign eng_kind = eng_kind_ff;
	assign eng_addr = eng_addr_ff;
	assign status_value = status_ff;
	assign nv_copy = nv_copy_ff;
	assign protect_mode = pmode_ff;
endmodule

// ==== testbench/fsr1_core_assertions.sv ====
// concurrent checks on the ports of the status register core
`timescale 1ns/1ps
module fsr1_core_assertions (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// spi and engine
	input wire logic cs_n,
	input wire logic eng_busy,
	input wire logic eng_done,
	input wire logic eng_req,
	// observed state
	input wire logic [7:0] status_value,
	input wire logic [1:0] protect_mode,
	input wire logic protect_select_high
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	// effects land two edges after the chip select rise
	sequence frame_closed;
		$past(cs_n, 2) && $past(cs_n, 1);
	endsequence
	sequence busy_end;
		$fell(status_value[0]);
	endsequence

	reset_clear_a: assert property ($rose(nrst) |-> status_value == 8'h00 && !eng_req)
		else $error("status not clear after reset");
	busy_mirror_a: assert property (eng_busy |-> ##[1:2] status_value[0])
		else $error("busy flag misses engine busy");
	req_busy_a: assert property (eng_req |-> ##[1:3] status_value[0])
		else $error("busy flag low after request");
	done_clear_a: assert property (eng_done |-> ##[1:3] !status_value[1])
		else $error("latch kept after completion");
	latch_rise_a: assert property ($rose(status_value[1]) |-> frame_closed)
		else $error("latch set inside a frame");
	fields_frame_a: assert property ($changed(status_value[7:2]) |-> frame_closed)
		else $error("fields changed inside a frame");
	busy_end_a: assert property (busy_end |-> ##[0:2] !status_value[1])
		else $error("latch kept after busy end");
	mode_map_a: assert property ($past(nrst) |->
		protect_mode == {$past(protect_select_high), status_value[7]})
		else $error("protection mode mismatch");
endmodule

bind fsr1_core fsr1_core_assertions u_chk (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.cs_n(cs_n),
	.eng_busy(eng_busy),
	.eng_done(eng_done),
	.eng_req(eng_req),
	.status_value(status_value),
	.protect_mode(protect_mode),
	.protect_select_high(protect_select_high)
);

// ==== testbench/fsr1_spi_host.sv ====
// spi host model issuing mode 0 frames to the core
`timescale 1ns/1ps
module fsr1_spi_host (
	// clock
	input wire logic clk_sys,
	// spi pins
	output logic cs_n,
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// msb first from bit 39; a long low phase lets miso settle after the fall
	task automatic frame(input logic [39:0] d, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		tick(1);
		cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			mosi = d[39-i];
			tick(3);
			sck = 1'b1;
			rx = {rx[6:0], miso};
			tick(2);
			sck = 1'b0;
		end
		tick(2);
		cs_n = 1'b1;
		// released line has no pull, so it must not keep the last bit
		mosi = ~mosi;
		tick(4);
	endtask
endmodule

// ==== testbench/fsr1_core_tb.sv ====
// self-checking bench for the status register core
`timescale 1ns/1ps
module fsr1_core_tb
	import fsr1_pkg::*;
;
	logic clk_sys = 1'b0;
	logic nrst, wp_n, cs_n, sck, mosi, miso, eng_req;
	logic eng_busy = 1'b0;
	logic eng_done = 1'b0;
	logic [2:0] eng_kind;
	logic [23:0] eng_addr;
	logic [7:0] status_value, nv_copy, v;
	logic [1:0] protect_mode;
	int miscompares = 0;
	int cmp_count = 0;
	int cyc = 0;
	int eng_cnt = 0;
	int n_req = 0;
	int n0;
	logic [7:0] t_sr [5] = '{8'h04, 8'h44, 8'h24, 8'h24, 8'h00};
	logic [23:0] t_adr [5] = '{24'h001000, 24'h001000, 24'h001000, 24'h1ff000, 24'h001000};
	logic t_wren [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	logic t_acc [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [7:0] t_op [5] = '{OP_ERASE4, OP_ERASE32, OP_ERASE64, OP_ERASE4, OP_ERASE4};
	logic [2:0] t_kind [5] = '{KIND_ERASE4, KIND_ERASE32, KIND_ERASE64, KIND_ERASE4, KIND_ERASE4};

	always #2 clk_sys = ~clk_sys;

	fsr1_core u_dut (
		.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
		.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso),
		.wp_n(wp_n), .protect_select_high(1'b0),
		.eng_busy(eng_busy), .eng_done(eng_done), .eng_req(eng_req),
		.eng_kind(eng_kind), .eng_addr(eng_addr),
		.status_value(status_value), .nv_copy(nv_copy), .protect_mode(protect_mode)
	);

	fsr1_spi_host u_host (.clk_sys(clk_sys), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));

	// array engine stand-in: busy for 16 cycles per request
	// each output is written once per edge: busy falls as the done pulse rises
	always @(posedge clk_sys) begin
		if (eng_req === 1'b1) begin
			n_req <= n_req + 1;
			eng_cnt <= 16;
		end else if (eng_cnt != 0) begin
			eng_cnt <= eng_cnt - 1;
		end
		eng_busy <= #1 (eng_req === 1'b1) || (eng_cnt > 1);
		eng_done <= #1 (eng_req !== 1'b1) && (eng_cnt == 1);
	end

	task automatic end_sim;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cmd(input logic [39:0] d, input int n);
		logic [7:0] rx;
		u_host.frame(d, n, rx);
	endtask

	task automatic rd(output logic [7:0] r);
		u_host.frame({OP_RDSR, 32'h0}, 16, r);
	endtask

	task automatic poll(output logic [7:0] r);
		int n;
		n = 0;
		rd(r);
		while (r[0] !== 1'b0 && n < 100) begin
			rd(r);
			n++;
		end
	endtask

	task automatic vwr(input logic [7:0] d);
		cmd({OP_VWREN, 32'h0}, 8);
		cmd({OP_WRSR, d, 24'h0}, 16);
	endtask

	initial begin
		nrst = 1'b0;
		wp_n = 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		rd(v);
		chk(v, SR_RESET);
		cmd({OP_WRSR, 8'hfc, 24'h0}, 16);
		rd(v);
		chk(v, 8'h00);
		cmd({OP_VWREN, 32'h0}, 8);
		rd(v);
		chk(v, 8'h00);
		cmd({OP_WRSR, 8'h24, 24'h0}, 16);
		rd(v);
		chk(v, 8'h24);
		chk(nv_copy, 8'h00);
		cmd({OP_WREN, 32'h0}, 8);
		rd(v);
		chk(v, 8'h26);
		cmd({OP_WREN, 32'h0}, 4);
		cmd({8'hff, 32'h0}, 8);
		rd(v);
		chk(v, 8'h26);
		cmd({OP_WRSR, 8'h5c, 24'h0}, 20);
		rd(v);
		chk(v, 8'h24);
		cmd({OP_WREN, 32'h0}, 8);
		cmd({OP_WRSR, 8'h5c, 24'h0}, 16);
		rd(v);
		chk(v, 8'h5f);
		poll(v);
		chk(v, 8'h5c);
		chk(nv_copy, 8'h5c);
		vwr(8'h80);
		rd(v);
		chk(protect_mode, 2'b01);
		wp_n = 1'b0;
		vwr(8'h00);
		rd(v);
		chk(v, 8'h80);
		wp_n = 1'b1;
		// granularity, direction and missing enable against one erase each
		for (int i = 0; i < 5; i++) begin
			vwr(t_sr[i]);
			if (t_wren[i]) begin
				cmd({OP_WREN, 32'h0}, 8);
			end
			n0 = n_req;
			cmd({t_op[i], t_adr[i], 8'h0}, 32);
			poll(v);
			chk(24'(n_req - n0), {23'h0, t_acc[i]});
			chk(v, t_sr[i]);
			if (t_acc[i]) begin
				chk(eng_addr, t_adr[i]);
				chk(eng_kind, t_kind[i]);
			end
		end
		// write disable, then program with and without the latch and chip erase with and without protection
		cmd({OP_WREN, 32'h0}, 8);
		cmd({OP_WRDI, 32'h0}, 8);
		n0 = n_req;
		cmd({OP_PROG, 24'h000100, 8'ha5}, 40);
		rd(v);
		chk(24'(n_req - n0), 24'h0);
		chk(v, SR_RESET);
		cmd({OP_WREN, 32'h0}, 8);
		cmd({OP_PROG, 24'h000100, 8'ha5}, 40);
		poll(v);
		chk(24'(n_req - n0), 24'h1);
		chk(eng_kind, KIND_PROG);
		chk(eng_addr, 24'h000100);
		chk(v, SR_RESET);
		vwr(8'h04);
		cmd({OP_WREN, 32'h0}, 8);
		n0 = n_req;
		cmd({OP_CHIP_B, 32'h0}, 8);
		rd(v);
		chk(24'(n_req - n0), 24'h0);
		chk(v, 8'h04);
		vwr(SR_RESET);
		cmd({OP_WREN, 32'h0}, 8);
		cmd({OP_CHIP_A, 32'h0}, 8);
		poll(v);
		chk(24'(n_req - n0), 24'h1);
		chk(eng_kind, KIND_CHIP);
		chk(v, SR_RESET);
		// reset in mid-run with the latch and fields set
		vwr(8'h24);
		cmd({OP_WREN, 32'h0}, 8);
		rd(v);
		chk(v, 8'h26);
		nrst = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		nrst = 1'b1;
		rd(v);
		chk(v, SR_RESET);
		end_sim();
	end
endmodule
